// ---- verification/nacd_disp_model.sv ----
`default_nettype none

module nacd_disp_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // dispatch handshake
  input wire logic i_valid,
  input wire logic [3:0] i_stall,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // -------------------------------------------------------------
  // slow or prompt taker; ready drops right after each take
  // -------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst || !i_valid || o_ready) begin
      cnt <= 4'h0;
      o_ready <= 1'b0;
    end else if (cnt >= i_stall) begin
      o_ready <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : nacd_disp_model

`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nacd_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_id = 16'h0000;
  logic cmd_ready, disp_valid, disp_ready, disp_read, err;
  logic [15:0] disp_id, err_id, acc_cnt, rej_cnt;
  nacd_access_t disp_access;
  logic [1:0] disp_bank, disp_size;
  logic [4:0] err_code;
  logic [3:0] stall = 4'h0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [15:0] exp_acc = 16'h0000;
  logic [15:0] exp_rej = 16'h0000;

  always #5 i_sys_clk = ~i_sys_clk;

  nacd_top dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_cmd_valid(cmd_valid), .i_cmd_id(cmd_id), .o_cmd_ready(cmd_ready),
    .o_disp_valid(disp_valid), .i_disp_ready(disp_ready),
    .o_disp_id(disp_id), .o_disp_access(disp_access),
    .o_disp_bank(disp_bank), .o_disp_size(disp_size),
    .o_disp_read(disp_read), .o_err(err), .o_err_code(err_code),
    .o_err_id(err_id), .o_accept_count(acc_cnt),
    .o_reject_count(rej_cnt));

  nacd_disp_model disp_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_valid(disp_valid), .i_stall(stall), .o_ready(disp_ready));

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // reasons worked out from the field layout
  function automatic logic [4:0] why(input logic [15:0] d);
    why[0] = d[15:12] != 4'hc || d[7] || d[3];
    why[1] = d[11:10] != 2'h1;
    why[2] = d[9:8] == 2'h2 ? !d[6] : d[6:4] != 3'h0;
    why[3] = d[2:1] == 2'h3;
    why[4] = d[9:8] == 2'h0 && d[2:1] != 2'h1;
  endfunction : why

  // one command offered for one edge; settles past the take edge
  task automatic send(input logic [15:0] d);
    @(posedge i_sys_clk);
    cmd_valid <= 1'b1;
    cmd_id <= d;
    @(posedge i_sys_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask : send

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic accept_one(input logic [15:0] d);
    int n;
    send(d);
    exp_acc++;
    chk("disp_valid", 16'h1, {15'h0, disp_valid});
    chk("disp_id", d, disp_id);
    chk("access", {14'h0, d[9:8]}, {14'h0, disp_access});
    chk("bank", {14'h0, d[9] ? d[5:4] : 2'h0}, 16'(disp_bank));
    chk("size", {14'h0, d[2:1]}, {14'h0, disp_size});
    chk("read", {15'h0, d[0]}, {15'h0, disp_read});
    chk("ready_busy", 16'h0, {15'h0, cmd_ready});
    chk("err_on_ok", 16'h0, {15'h0, err});
    chk("acc_cnt", exp_acc, acc_cnt);
    n = 0;
    while (disp_valid === 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk("released", 16'h1, {15'h0, cmd_ready & ~disp_valid});
  endtask : accept_one

  task automatic legal_all;
    logic [15:0] d;
    accept_one(16'hc402);
    accept_one(16'hc403);
    for (int k = 0; k < 6; k++) begin
      stall = k[3:0];
      d = 16'hc500 | k[15:0];
      accept_one(d);
      d = 16'hc700 | k[15:0];
      accept_one(d);
      for (int b = 4; b < 8; b++) begin
        d = 16'hc600 | (b[15:0] << 4) | k[15:0];
        accept_one(d);
      end
    end
  endtask : legal_all

  task automatic reject_one(input logic [15:0] d);
    send(d);
    exp_rej++;
    chk("err", 16'h1, {15'h0, err});
    chk("err_code", {11'h0, why(d)}, {11'h0, err_code});
    chk("err_id", d, err_id);
    chk("no_disp", 16'h0, {15'h0, disp_valid});
    chk("rej_cnt", exp_rej, rej_cnt);
    chk("acc_kept", exp_acc, acc_cnt);
    @(posedge i_sys_clk);
    #1;
    chk("err_pulse", 16'h0, {15'h0, err});
  endtask : reject_one

  task automatic illegal_all;
    logic [15:0] bad [14] = '{16'h4402, 16'hc482, 16'hc40a, 16'hc802,
      16'hc002, 16'hc412, 16'hc400, 16'hc404, 16'hc506, 16'hc600,
      16'hc630, 16'hc646, 16'hc710, 16'hc406};
    foreach (bad[i]) reject_one(bad[i]);
  endtask : illegal_all

  task automatic reject_b2b;
    @(posedge i_sys_clk);
    cmd_valid <= 1'b1;
    cmd_id <= 16'hc506;
    @(posedge i_sys_clk);
    cmd_id <= 16'hc802;
    #1;
    chk("b2b_err1", 16'hc506, err ? err_id : 16'h0);
    @(posedge i_sys_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("b2b_err2", 16'hc802, err ? err_id : 16'h0);
    exp_rej += 16'h2;
    chk("b2b_cnt", exp_rej, rej_cnt);
  endtask : reject_b2b

  // offers made while a dispatch is pending are not taken
  task automatic busy_refuse;
    int n;
    stall <= 4'h5;
    send(16'hc643);
    exp_acc++;
    chk("busy_valid", 16'h1, {15'h0, disp_valid});
    @(posedge i_sys_clk);
    cmd_valid <= 1'b1;
    cmd_id <= 16'hc400;
    repeat (2) @(posedge i_sys_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("busy_no_err", 16'h0, {15'h0, err});
    chk("busy_rej", exp_rej, rej_cnt);
    chk("busy_id", 16'hc643, disp_id);
    n = 0;
    while (disp_valid === 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk("busy_released", 16'h1, {15'h0, cmd_ready & ~disp_valid});
    chk("busy_acc", exp_acc, acc_cnt);
  endtask : busy_refuse

  // reset while a dispatch is pending clears every other output and raises cmd_ready
  task automatic mid_reset;
    send(16'hc701);
    chk("mid_valid", 16'h1, {15'h0, disp_valid});
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    chk("mid_outs", 16'h0, {14'h0, disp_valid, err});
    chk("mid_cnts", 16'h0, acc_cnt | rej_cnt);
    chk("mid_ready", 16'h1, {15'h0, cmd_ready});
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk("mid_idle", 16'h1, {15'h0, cmd_ready & ~disp_valid});
    exp_acc = 16'h0;
    exp_rej = 16'h0;
  endtask : mid_reset

  initial begin
    repeat (19) @(posedge i_sys_clk);
    #1;
    chk("rst_ready", 16'h1, {15'h0, cmd_ready});
    chk("rst_outs", 16'h0, {14'h0, disp_valid, err});
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk("rst_cnts", 16'h0, acc_cnt | rej_cnt);
    legal_all();
    illegal_all();
    reject_b2b();
    busy_refuse();
    mid_reset();
    accept_one(16'hc675);
    results();
  end

  initial begin
    #100us;
    error_cnt++;
    results();
  end
endmodule : tb_top

`default_nettype wire

// ---- verilog/nacd_dec_if.sv ----
`default_nettype none

interface nacd_dec_if;
  import nacd_pkg::*;
  logic [ID_W-1:0] id;
  logic legal;
  nacd_access_t access;
  logic [1:0] bank;
  logic [1:0] size;
  logic read;
  logic [ERR_W-1:0] err;

  modport dec (
    input id,
    output legal, access, bank, size, read, err
  );
  modport use_side (
    output id,
    input legal, access, bank, size, read, err
  );
endinterface : nacd_dec_if

`default_nettype wire

// ---- verilog/nacd_event_count.sv ----
`default_nettype none

module nacd_event_count #(
  parameter int W = nacd_pkg::CNT_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // event
  input wire logic i_inc,
  output logic [W-1:0] o_count
);
  logic [W-1:0] next_count;

  // saturates so a long run never wraps to a small figure
  always_comb begin
    next_count = o_count;
    if (i_inc && (o_count != {W{1'b1}})) begin
      next_count = o_count + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_count <= '0;
    end else begin
      o_count <= next_count;
    end
  end
endmodule : nacd_event_count

`default_nettype wire

// ---- verilog/nacd_field_decode.sv ----
`default_nettype none

module nacd_field_decode (
  nacd_dec_if.dec dif
);
  import nacd_pkg::*;

  logic [3:0] hdr;
  logic [1:0] proc_f;
  logic [2:0] sub_f;
  logic [1:0] size_f;

  always_comb begin
    hdr = dif.id[HDR_MSB:HDR_LSB];
    proc_f = dif.id[PROC_MSB:PROC_LSB];
    sub_f = dif.id[SUB_MSB:SUB_LSB];
    size_f = dif.id[SIZE_MSB:SIZE_LSB];
    dif.access = nacd_access_t'(dif.id[ACC_MSB:ACC_LSB]); // [RULE_03]
    dif.bank = sub_f[1:0]; // [RULE_05]
    dif.size = size_f; // [RULE_06]
    dif.read = dif.id[RW_BIT]; // [RULE_07]
    dif.err = '0;
    // fixed header and the two zero bits
    dif.err[ERR_HDR] = (hdr != HDR_VAL) || dif.id[ZERO_HI]
      || dif.id[ZERO_LO]; // [RULE_01]
    dif.err[ERR_PROC] = (proc_f != PROC_IMG_SPACE); // [RULE_02]
    dif.err[ERR_SIZE] = (size_f == SIZE_BAD); // [RULE_02]
    // only the upper half of the subtype range names a bank
    if (dif.access == NACD_MEM) begin
      dif.err[ERR_SUB] = !sub_f[2]; // [RULE_05] [RULE_11]
    end else begin
      dif.err[ERR_SUB] = (sub_f != SUB_NONE); // [RULE_04] [RULE_12]
    end
    dif.err[ERR_REG_SIZE] = (dif.access == NACD_REG)
      && (size_f != SIZE_16); // [RULE_08]
    dif.legal = (dif.err == '0); // [RULE_02] [RULE_09] [RULE_10]
  end
endmodule : nacd_field_decode

`default_nettype wire

// ---- verilog/nacd_pkg.sv ----
// Function
// RULE_01: id is 16 bits, 1100 header, bits 7,3 zero
// RULE_02: any unlisted field value is invalid
// RULE_03: access type picks reg, var, mem, raw
// RULE_04: subtype must be zero unless memory access
// RULE_05: memory subtypes 4..7 pick overlay banks 0..3
// RULE_06: size code 0,1,2 means 8,16,32 bits
// RULE_07: bit 0 low writes, high reads
// RULE_08: register access only c402 and c403
// RULE_09: variable access accepts c500 to c505
// RULE_10: overlay banks 0,1 accept c640..5, c650..5
// RULE_11: overlay banks 2,3 accept c660..5, c670..5
// RULE_12: raw access accepts c700 to c705
// RULE_13: invalid id raises error, starts no access
`default_nettype none

package nacd_pkg;
  // ---------------------------------------------------------------
  // identifier layout
  // ---------------------------------------------------------------
  localparam int ID_W = 16;
  localparam int HDR_MSB = 15;
  localparam int HDR_LSB = 12;
  localparam logic [3:0] HDR_VAL = 4'hc;
  localparam int PROC_MSB = 11;
  localparam int PROC_LSB = 10;
  localparam logic [1:0] PROC_IMG_SPACE = 2'h1;
  localparam int ACC_MSB = 9;
  localparam int ACC_LSB = 8;
  localparam int ZERO_HI = 7;
  localparam int SUB_MSB = 6;
  localparam int SUB_LSB = 4;
  localparam int ZERO_LO = 3;
  localparam int SIZE_MSB = 2;
  localparam int SIZE_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [2:0] SUB_NONE = 3'h0;
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [1:0] SIZE_BAD = 2'h3;

  typedef enum logic [1:0] {
    NACD_REG = 2'h0,
    NACD_VAR = 2'h1,
    NACD_MEM = 2'h2,
    NACD_RAW = 2'h3
  } nacd_access_t;

  // ---------------------------------------------------------------
  // error code bits
  // ---------------------------------------------------------------
  localparam int ERR_W = 5;
  localparam int ERR_HDR = 0;
  localparam int ERR_PROC = 1;
  localparam int ERR_SUB = 2;
  localparam int ERR_SIZE = 3;
  localparam int ERR_REG_SIZE = 4;
  localparam int CNT_W = 16;

  // ---------------------------------------------------------------
  // listed legal identifiers, kept apart from the field logic
  // ---------------------------------------------------------------
  localparam logic [15:0] ID_REG_SET = 16'hc402;
  localparam logic [15:0] ID_REG_GET = 16'hc403;
  localparam logic [7:0] ID_LOW_LAST = 8'h05;
  localparam logic [7:0] ID_VAR_HI = 8'hc5;
  localparam logic [7:0] ID_MEM_HI = 8'hc6;
  localparam logic [7:0] ID_RAW_HI = 8'hc7;
  localparam logic [3:0] ID_BANK0_NIB = 4'h4;

  function automatic logic nacd_listed(input logic [15:0] id);
    logic lo_ok;
    logic mem_ok;
    lo_ok = (id[3:0] <= ID_LOW_LAST[3:0]);
    // bit 7 must stay clear, so the bank nibble runs 4..7 only
    mem_ok = (id[15:8] == ID_MEM_HI) && (id[7:4] >= ID_BANK0_NIB)
      && !id[7] && lo_ok;
    return (id == ID_REG_SET) || (id == ID_REG_GET)
      || (id[15:8] == ID_VAR_HI && id[7:0] <= ID_LOW_LAST)
      || mem_ok
      || (id[15:8] == ID_RAW_HI && id[7:0] <= ID_LOW_LAST);
  endfunction : nacd_listed
endpackage : nacd_pkg

`default_nettype wire

// ---- verilog/nacd_top.sv ----
`default_nettype none

module nacd_top #(
  parameter int CW = nacd_pkg::CNT_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // command from host
  input wire logic i_cmd_valid,
  input wire logic [nacd_pkg::ID_W-1:0] i_cmd_id,
  output logic o_cmd_ready,
  // request to access dispatcher
  output logic o_disp_valid,
  input wire logic i_disp_ready,
  output logic [nacd_pkg::ID_W-1:0] o_disp_id,
  output nacd_pkg::nacd_access_t o_disp_access,
  output logic [1:0] o_disp_bank,
  output logic [1:0] o_disp_size,
  output logic o_disp_read,
  // rejection report
  output logic o_err,
  output logic [nacd_pkg::ERR_W-1:0] o_err_code,
  output logic [nacd_pkg::ID_W-1:0] o_err_id,
  // running tallies
  output logic [CW-1:0] o_accept_count,
  output logic [CW-1:0] o_reject_count
);
  import nacd_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_HOLD = 2'b10
  } nacd_state_t;

  nacd_state_t state;
  nacd_state_t next_state;
  logic take;
  logic accept;
  logic reject;
  logic next_disp_valid;
  logic [ID_W-1:0] next_disp_id;
  nacd_access_t next_disp_access;
  logic [1:0] next_disp_bank;
  logic [1:0] next_disp_size;
  logic next_disp_read;
  logic next_err;
  logic [ERR_W-1:0] next_err_code;
  logic [ID_W-1:0] next_err_id;

  nacd_dec_if dif ();

  assign dif.id = i_cmd_id;

  nacd_field_decode u_decode (
    .dif (dif)
  );

  // ---------------------------------------------------------------
  // handshake
  // ---------------------------------------------------------------
  // one command in flight: the host waits while the dispatcher stalls
  assign o_cmd_ready = (state == S_IDLE);
  assign take = i_cmd_valid && o_cmd_ready;
  assign accept = take && dif.legal;
  assign reject = take && !dif.legal; // [RULE_13]

  always_comb begin
    next_state = state;
    next_disp_valid = o_disp_valid;
    next_disp_id = o_disp_id;
    next_disp_access = o_disp_access;
    next_disp_bank = o_disp_bank;
    next_disp_size = o_disp_size;
    next_disp_read = o_disp_read;
    case (state)
      S_IDLE: begin
        // a rejected id never reaches the dispatcher
        if (accept) begin
          next_state = S_HOLD;
          next_disp_valid = 1'b1; // [RULE_13]
          next_disp_id = i_cmd_id;
          next_disp_access = dif.access; // [RULE_03]
          next_disp_bank = dif.bank; // [RULE_05]
          next_disp_size = dif.size; // [RULE_06]
          next_disp_read = dif.read; // [RULE_07]
        end
      end
      S_HOLD: begin
        if (i_disp_ready) begin
          next_state = S_IDLE;
          next_disp_valid = 1'b0;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_disp_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= S_IDLE;
      o_disp_valid <= 1'b0;
      o_disp_id <= '0;
      o_disp_access <= NACD_REG;
      o_disp_bank <= '0;
      o_disp_size <= '0;
      o_disp_read <= 1'b0;
    end else begin
      state <= next_state;
      o_disp_valid <= next_disp_valid;
      o_disp_id <= next_disp_id;
      o_disp_access <= next_disp_access;
      o_disp_bank <= next_disp_bank;
      o_disp_size <= next_disp_size;
      o_disp_read <= next_disp_read;
    end
  end

  // ---------------------------------------------------------------
  // rejection report
  // ---------------------------------------------------------------
  // code and id stay until the next rejection for late readers
  always_comb begin
    next_err = reject; // [RULE_13]
    next_err_code = o_err_code;
    next_err_id = o_err_id;
    if (reject) begin
      next_err_code = dif.err; // [RULE_02]
      next_err_id = i_cmd_id;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_err <= 1'b0;
      o_err_code <= '0;
      o_err_id <= '0;
    end else begin
      o_err <= next_err;
      o_err_code <= next_err_code;
      o_err_id <= next_err_id;
    end
  end

  // ---------------------------------------------------------------
  // tallies
  // ---------------------------------------------------------------
  nacd_event_count #(.W(CW)) u_acc_cnt (
    .i_sys_clk (i_sys_clk),
    .i_rst (i_rst),
    .i_inc (accept),
    .o_count (o_accept_count)
  );

  nacd_event_count #(.W(CW)) u_rej_cnt (
    .i_sys_clk (i_sys_clk),
    .i_rst (i_rst),
    .i_inc (reject),
    .o_count (o_reject_count)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_take;
    i_cmd_valid && o_cmd_ready;
  endsequence

  sequence s_bad_take;
    s_take ##0 !nacd_listed(i_cmd_id);
  endsequence

  sequence s_good_take;
    s_take ##0 nacd_listed(i_cmd_id);
  endsequence

  sequence s_stall;
    o_disp_valid && !i_disp_ready;
  endsequence

  AST_HEADER_BITS: assert property ( // [RULE_01]
    s_take ##0 (i_cmd_id[HDR_MSB:HDR_LSB] != HDR_VAL
      || i_cmd_id[ZERO_HI] || i_cmd_id[ZERO_LO])
    |=> o_err && o_err_code[ERR_HDR] && !o_disp_valid)
    else $error("bad header or zero bit not rejected");

  AST_SIZE_THREE: assert property ( // [RULE_02]
    s_take ##0 (i_cmd_id[SIZE_MSB:SIZE_LSB] == SIZE_BAD)
    |=> o_err && o_err_code[ERR_SIZE])
    else $error("size code 3 not rejected");

  AST_PROC_FIELD: assert property ( // [RULE_02]
    s_take ##0 (i_cmd_id[PROC_MSB:PROC_LSB] != PROC_IMG_SPACE)
    |=> o_err && o_err_code[ERR_PROC])
    else $error("processor field other than 1 accepted");

  AST_ACCESS_TYPE: assert property ( // [RULE_03]
    s_good_take |=> o_disp_valid
      && o_disp_access == $past(i_cmd_id[ACC_MSB:ACC_LSB]))
    else $error("access type not carried to dispatcher");

  AST_SUBTYPE_ZERO: assert property ( // [RULE_04]
    s_take ##0 (i_cmd_id[ACC_MSB:ACC_LSB] != NACD_MEM
      && i_cmd_id[SUB_MSB:SUB_LSB] != SUB_NONE)
    |=> o_err && o_err_code[ERR_SUB])
    else $error("nonzero subtype accepted outside memory access");

  AST_BANK_SELECT: assert property ( // [RULE_05]
    s_good_take ##0 (i_cmd_id[ACC_MSB:ACC_LSB] == NACD_MEM)
    |=> o_disp_bank == $past(i_cmd_id[SUB_MSB:SUB_LSB]) - 3'h4)
    else $error("overlay bank does not follow subtype");

  AST_ITEM_SIZE: assert property ( // [RULE_06]
    s_good_take |=> o_disp_size == $past(i_cmd_id[SIZE_MSB:SIZE_LSB])
      && o_disp_size != SIZE_BAD)
    else $error("item size not carried to dispatcher");

  AST_DIRECTION: assert property ( // [RULE_07]
    s_good_take |=> o_disp_read == $past(i_cmd_id[RW_BIT]))
    else $error("direction bit not carried to dispatcher");

  AST_REG_IDS: assert property ( // [RULE_08]
    s_take ##0 (i_cmd_id[ACC_MSB:ACC_LSB] == NACD_REG)
    |=> o_disp_valid == ($past(i_cmd_id) == ID_REG_SET
      || $past(i_cmd_id) == ID_REG_GET))
    else $error("register access id set wrong");

  AST_VAR_IDS: assert property ( // [RULE_09]
    s_take ##0 (i_cmd_id[15:8] == ID_VAR_HI)
    |=> o_disp_valid == ($past(i_cmd_id[7:0]) <= ID_LOW_LAST))
    else $error("variable access id set wrong");

  AST_OVL_LOW_IDS: assert property ( // [RULE_10]
    s_take ##0 (i_cmd_id[15:8] == ID_MEM_HI && i_cmd_id[5] == 1'b0)
    |=> o_disp_valid == nacd_listed($past(i_cmd_id)))
    else $error("overlay bank 0 or 1 id set wrong");

  AST_OVL_HIGH_IDS: assert property ( // [RULE_11]
    s_take ##0 (i_cmd_id[15:8] == ID_MEM_HI && i_cmd_id[5] == 1'b1)
    |=> o_disp_valid == nacd_listed($past(i_cmd_id)))
    else $error("overlay bank 2 or 3 id set wrong");

  AST_RAW_IDS: assert property ( // [RULE_12]
    s_take ##0 (i_cmd_id[15:8] == ID_RAW_HI)
    |=> o_disp_valid == ($past(i_cmd_id[7:0]) <= ID_LOW_LAST))
    else $error("raw access id set wrong");

  AST_REJECT_NO_ACCESS: assert property ( // [RULE_13]
    s_bad_take |=> o_err && !o_disp_valid
      ##1 o_cmd_ready && (!o_err || $past(i_cmd_valid)))
    else $error("rejected id started an access");

  AST_HOLD_STABLE: assert property ( // [RULE_13]
    s_stall |=> o_disp_valid && $stable(o_disp_id) && !o_cmd_ready)
    else $error("dispatch request dropped or changed while stalled");
endmodule : nacd_top

`default_nettype wire
